// ===== spi_slave_port.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Functional notes
// RULE1: mask bit 6 gates select-rise interrupt
// RULE2: mask bit 5 gates select-fall interrupt
// RULE3: mask bit 4 gates transfer-done interrupt
// RULE4: bit 3 picks LSB-first bit order
// RULE5: bit 2 sets serial clock polarity
// RULE6: bit 1 sets sample/shift clock phase
// RULE7: bit 0 enables the slave core
// RULE8: flag 5 marks select rise, read-clear
// RULE9: flag 4 marks select fall, read-clear
// RULE10: flag 0 marks byte done, read-clear
// RULE11: three maskable sources, flags show which
// RULE12: data register: write TX, read RX
// RULE13: two TX preloads, one while deselected
// RULE14: first preload shifts out full duplex
// RULE15: firmware keeps two bytes in chain
// RULE16: master pauses after single-byte preload
// RULE17: four modes map polarity/phase to edges
// RULE18: irq when any unmasked flag set
// RULE19: drive serial out only while selected
// RULE20: serial events synchronised before flags
module spi_slave_port (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [9:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [9:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  input  wire logic        slave_select_n_in,
  input  wire logic        slave_serial_clock_in,
  input  wire logic        slave_serial_in_in,
  output logic             slave_serial_out_out,
  output logic             slave_serial_out_oe_out,
  output logic             irq_out
);
  // address hits a register index
  function automatic logic hit(input logic [9:0] a, input logic [7:0] i);
    return a[9:2] == i;
  endfunction
  // pick the bit that goes out for position i
  function automatic logic pick(input logic [7:0] b, input logic [2:0] i, input logic lsb);
    return lsb ? b[i] : b[3'h7 - i];
  endfunction

  // pins: bit 0 select, bit 1 clock, bit 2 data in
  logic [2:0]  s1_q, s2_q, s3_q;   // three-stage synchroniser
  logic [2:0]  filt_q, filt_d;     // agreed pin levels
  logic [6:0]  cfg_q, cfg_d;       // configuration
  logic [5:0]  flags_q, flags_d;   // event flags
  logic [7:0]  rx_q, rx_d;         // receive buffer
  logic [7:0]  rsh_q, rsh_d;       // receive shifter
  logic [7:0]  cur_q, cur_d;       // byte now shifting out
  logic [7:0]  tb0_q, tb0_d;       // tx chain head
  logic [7:0]  tb1_q, tb1_d;       // tx chain tail
  logic [1:0]  tcnt_q, tcnt_d;     // bytes in tx chain
  logic [2:0]  bcnt_q, bcnt_d;     // bit position
  logic        out_q, out_d;       // serial out level
  logic        oe_q, oe_d;         // serial out enable
  logic        irq_q, irq_d;       // interrupt line
  logic        en, sel, sel_fall, sel_rise, ck_rise, ck_fall, lead, trail;
  logic        samp, shft, done_ev, pop, push;
  // bus state
  logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic        awh_q, awh_d, wh_q, wh_d;
  logic [9:0]  wa_q, wa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        aw_got, w_got, ar_got, fire, wr_ok, data_wr, stat_clr;

  // synchroniser stages, only the second stage reads the first [RULE20]
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s1_q <= spi_slave_pkg::PIN_RST;
      s2_q <= spi_slave_pkg::PIN_RST;
      s3_q <= spi_slave_pkg::PIN_RST;
    end
    else
    begin
      s1_q <= {slave_serial_in_in, slave_serial_clock_in, slave_select_n_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level changes once stages two and three agree; edges from that
  always_comb
  begin
    filt_d   = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
    en       = cfg_q[spi_slave_pkg::EN_BIT];  // core runs only when enabled [RULE7]
    sel      = en & ~filt_q[0];
    sel_fall = en & filt_q[0] & ~filt_d[0];
    sel_rise = en & ~filt_q[0] & filt_d[0];
    ck_rise  = ~filt_q[1] & filt_d[1];
    ck_fall  = filt_q[1] & ~filt_d[1];
    // leading edge leaves the idle level [RULE5]
    lead     = cfg_q[spi_slave_pkg::CPOL_BIT] ? ck_fall : ck_rise;
    trail    = cfg_q[spi_slave_pkg::CPOL_BIT] ? ck_rise : ck_fall;
    // phase chooses sample and shift edges [RULE6] [RULE17]
    samp     = sel & (cfg_q[spi_slave_pkg::CPHA_BIT] ? trail : lead);
    shft     = sel & (cfg_q[spi_slave_pkg::CPHA_BIT] ? lead : trail);
    done_ev  = samp & (bcnt_q == 3'h7);
  end

  // serial engine and tx chain
  always_comb
  begin
    rsh_d  = rsh_q;
    rx_d   = rx_q;
    cur_d  = cur_q;
    bcnt_d = bcnt_q;
    out_d  = out_q;
    tb0_d  = tb0_q;
    tb1_d  = tb1_q;
    tcnt_d = tcnt_q;
    // head moves to the shifter at select fall and after each byte [RULE14]
    pop    = (sel_fall | done_ev) & (tcnt_q != 2'h0);
    // only one preload while deselected, two once selected [RULE13]
    push   = data_wr & (filt_q[0] ? (tcnt_q == 2'h0) : (tcnt_q != 2'h2));
    if (samp)
    begin
      // shift in per bit order [RULE4]
      rsh_d  = cfg_q[spi_slave_pkg::LSB_BIT] ? {filt_q[2], rsh_q[7:1]} : {rsh_q[6:0], filt_q[2]};
      bcnt_d = bcnt_q + 3'h1;
    end
    if (done_ev)
    begin
      // byte complete: to rx buffer, next byte loads [RULE12] [RULE15]
      rx_d  = rsh_d;
      cur_d = pop ? tb0_q : spi_slave_pkg::DATA_RST;
    end
    if (sel_fall)
    begin
      // first bit ready before the first clock edge
      bcnt_d = 3'h0;
      cur_d  = pop ? tb0_q : spi_slave_pkg::DATA_RST;
      out_d  = pick(cur_d, 3'h0, cfg_q[spi_slave_pkg::LSB_BIT]);
    end
    else if (shft)
    begin
      // drive next bit on the shift edge [RULE4] [RULE17]
      out_d = pick(cur_q, bcnt_q, cfg_q[spi_slave_pkg::LSB_BIT]);
    end
    // chain bookkeeping
    case ({push, pop})
      2'b10:
      begin
        if (tcnt_q == 2'h0) tb0_d = wd_d[7:0];
        else tb1_d = wd_d[7:0];
        tcnt_d = tcnt_q + 2'h1;
      end
      2'b01:
      begin
        tb0_d  = tb1_q;
        tcnt_d = tcnt_q - 2'h1;
      end
      2'b11:
      begin
        if (tcnt_q == 2'h1) tb0_d = wd_d[7:0];
        else
        begin
          tb0_d = tb1_q;
          tb1_d = wd_d[7:0];
        end
      end
      default:
      begin
        tcnt_d = tcnt_q;
      end
    endcase
    // drive only while selected [RULE19]
    oe_d = en & ~filt_d[0];
    if (!oe_d) out_d = 1'b0;
  end

  // flags and config; a new event beats the read clear
  always_comb
  begin
    cfg_d   = cfg_q;
    flags_d = flags_q;
    if (fire && wr_ok && hit(wa_d, spi_slave_pkg::CFG_IDX))
      cfg_d = wd_d[6:0];
    if (stat_clr)
      flags_d = spi_slave_pkg::FLAG_RST;  // cleared on read [RULE8] [RULE9] [RULE10]
    if (sel_rise) flags_d[spi_slave_pkg::RISE_BIT] = 1'b1;  // [RULE8]
    if (sel_fall) flags_d[spi_slave_pkg::FALL_BIT] = 1'b1;  // [RULE9]
    if (done_ev)  flags_d[spi_slave_pkg::DONE_BIT] = 1'b1;  // [RULE10]
    // each source gated by its own mask [RULE1] [RULE2] [RULE3] [RULE11] [RULE18]
    irq_d = (flags_d[spi_slave_pkg::RISE_BIT] & ~cfg_d[spi_slave_pkg::MRISE_BIT])
          | (flags_d[spi_slave_pkg::FALL_BIT] & ~cfg_d[spi_slave_pkg::MFALL_BIT])
          | (flags_d[spi_slave_pkg::DONE_BIT] & ~cfg_d[spi_slave_pkg::MDONE_BIT]);
  end

  // bus slave: address and data in either order, answer after both
  always_comb
  begin
    aw_got   = awvalid_in & awr_q;
    w_got    = wvalid_in & wr_q;
    ar_got   = arvalid_in & arr_q;
    wa_d     = aw_got ? awaddr_in : wa_q;
    wd_d     = w_got ? wdata_in : wd_q;
    ws_d     = w_got ? wstrb_in : ws_q;
    fire     = (awh_q | aw_got) & (wh_q | w_got) & ~bv_q;
    wr_ok    = hit(wa_d, spi_slave_pkg::CFG_IDX) | hit(wa_d, spi_slave_pkg::STAT_IDX)
             | hit(wa_d, spi_slave_pkg::DATA_IDX);
    data_wr  = fire & ws_d[0] & hit(wa_d, spi_slave_pkg::DATA_IDX);  // write loads tx [RULE12]
    stat_clr = ar_got & hit(araddr_in, spi_slave_pkg::STAT_IDX);
    awh_d    = (awh_q | aw_got) & ~fire;
    wh_d     = (wh_q | w_got) & ~fire;
    awr_d    = (bv_q & bready_in) | (awr_q & ~aw_got);
    wr_d     = (bv_q & bready_in) | (wr_q & ~w_got);
    bv_d     = fire | (bv_q & ~bready_in);
    br_d     = fire ? (wr_ok ? spi_slave_pkg::RESP_OK : spi_slave_pkg::RESP_ERR) : br_q;
    arr_d    = (rv_q & rready_in) | (arr_q & ~ar_got);
    rv_d     = ar_got | (rv_q & ~rready_in);
    rd_d     = rd_q;
    rr_d     = rr_q;
    if (ar_got)
    begin
      rr_d = spi_slave_pkg::RESP_OK;
      if (hit(araddr_in, spi_slave_pkg::CFG_IDX)) rd_d = {25'h0, cfg_q};
      else if (hit(araddr_in, spi_slave_pkg::STAT_IDX)) rd_d = {26'h0, flags_q};  // [RULE11]
      else if (hit(araddr_in, spi_slave_pkg::DATA_IDX)) rd_d = {24'h0, rx_q};  // read gives rx [RULE12]
      else
      begin
        rd_d = 32'h0000_0000;
        rr_d = spi_slave_pkg::RESP_ERR;
      end
    end
  end

  // register all state except the synchroniser stages
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      filt_q <= spi_slave_pkg::PIN_RST;
      cfg_q  <= spi_slave_pkg::CFG_RST;
      flags_q <= spi_slave_pkg::FLAG_RST;
      {rx_q, rsh_q, cur_q, tb0_q, tb1_q} <= '0;
      {tcnt_q, bcnt_q, out_q, oe_q, irq_q} <= '0;
      {awr_q, wr_q, arr_q} <= 3'h7;
      {bv_q, rv_q, awh_q, wh_q} <= 4'h0;
      {wa_q, wd_q, ws_q, rd_q, br_q, rr_q} <= '0;
    end
    else
    begin
      filt_q <= filt_d;
      cfg_q  <= cfg_d;
      flags_q <= flags_d;
      {rx_q, rsh_q, cur_q, tb0_q, tb1_q} <= {rx_d, rsh_d, cur_d, tb0_d, tb1_d};
      {tcnt_q, bcnt_q, out_q, oe_q, irq_q} <= {tcnt_d, bcnt_d, out_d, oe_d, irq_d};
      {awr_q, wr_q, arr_q} <= {awr_d, wr_d, arr_d};
      {bv_q, rv_q, awh_q, wh_q} <= {bv_d, rv_d, awh_d, wh_d};
      {wa_q, wd_q, ws_q, rd_q, br_q, rr_q} <= {wa_d, wd_d, ws_d, rd_d, br_d, rr_d};
    end
  end

  assign awready_out             = awr_q;
  assign wready_out              = wr_q;
  assign bvalid_out              = bv_q;
  assign bresp_out               = br_q;
  assign arready_out             = arr_q;
  assign rvalid_out              = rv_q;
  assign rdata_out               = rd_q;
  assign rresp_out               = rr_q;
  assign slave_serial_out_out    = out_q;
  assign slave_serial_out_oe_out = oe_q;
  assign irq_out                 = irq_q;

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  rise_mask_a: assert property (flags_q[5] && !cfg_q[6] && !stat_clr && !fire |=> irq_q) // [RULE1]
    else $error("unmasked select-rise flag gave no irq");
  fall_mask_a: assert property (cfg_q[5] && cfg_q[4] && cfg_q[6] && !fire |=> !irq_q) // [RULE2]
    else $error("irq raised with all sources masked");
  done_mask_a: assert property (flags_q[0] && !cfg_q[4] && !stat_clr && !fire |=> irq_q) // [RULE3]
    else $error("unmasked done flag gave no irq");
  rise_flag_a: assert property (sel_rise |=> flags_q[5]) // [RULE8]
    else $error("select rise not flagged");
  fall_flag_a: assert property (sel_fall |=> flags_q[4] && bcnt_q == 3'h0) // [RULE9]
    else $error("select fall not flagged");
  done_flag_a: assert property (done_ev |-> bcnt_q == 3'h7 ##1 flags_q[0]) // [RULE10]
    else $error("byte done not flagged");
  read_clear_a: assert property (stat_clr && !sel_rise && !sel_fall && !done_ev |=> flags_q == 6'h00) // [RULE8] [RULE9] [RULE10]
    else $error("status read left flags set");
  drive_sel_a: assert property (oe_q |-> !filt_q[0] && cfg_q[0]) // [RULE19]
    else $error("serial out driven while deselected");
  preload_one_a: assert property (data_wr && filt_q[0] && !sel_fall && tcnt_q == 2'h1 |=> tcnt_q == 2'h1) // [RULE13]
    else $error("second preload taken while deselected");
  idle_core_a: assert property (!cfg_q[0] ##1 !cfg_q[0] |-> $stable(bcnt_q) && !oe_q) // [RULE7]
    else $error("core moved while disabled");
  cover_done_c: cover property (done_ev ##[1:300] done_ev);
  cover_irq_c: cover property ($rose(irq_q));
  cover_full_c: cover property (tcnt_q == 2'h2);
  cover_rise_c: cover property (sel_rise);
endmodule

// ===== spi_slave_pkg.sv
package spi_slave_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] CFG_IDX   = 8'hbc;
  localparam logic [7:0] STAT_IDX  = 8'hbe;
  localparam logic [7:0] DATA_IDX  = 8'hbf;
  localparam int         ADDR_W    = 10;
  // config fields
  localparam int         EN_BIT    = 0;
  localparam int         CPHA_BIT  = 1;
  localparam int         CPOL_BIT  = 2;
  localparam int         LSB_BIT   = 3;
  localparam int         MDONE_BIT = 4;
  localparam int         MFALL_BIT = 5;
  localparam int         MRISE_BIT = 6;
  // event flag fields
  localparam int         DONE_BIT  = 0;
  localparam int         FALL_BIT  = 4;
  localparam int         RISE_BIT  = 5;
  // reset values
  localparam logic [6:0] CFG_RST   = 7'h70;
  localparam logic [5:0] FLAG_RST  = 6'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [2:0] PIN_RST   = 3'h1;
  // bus answers
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;
endpackage

// ===== spi_master_model.sv
`timescale 1ns/1ns
// external master: frames one byte at a time, clock idle outside frames
module spi_master_model (
  input  wire logic miso_in,
  output logic      select_n_out,
  output logic      sclk_out,
  output logic      mosi_out
);
  // idle lines at time zero
  initial
  begin
    select_n_out = 1'b1;
    sclk_out     = 1'b0;
    mosi_out     = 1'b0;
  end

  // one selected byte, 125 ns clock, full duplex
  task automatic xfer(input logic cpol, input logic cpha, input logic lsb,
                      input logic [7:0] tx, output logic [7:0] rx);
    int b;
    begin
      sclk_out = cpol;  // clock parked at its idle level
      #20;
      select_n_out = 1'b0;
      #100;
      for (int i = 0; i < 8; i++)
      begin
        b = lsb ? i : 7 - i;  // bit order within the byte
        if (!cpha)
          mosi_out = tx[b];
        #62 sclk_out = ~cpol;  // leading edge
        if (cpha)
          mosi_out = tx[b];  // shift on leading edge
        else
          rx[b] = miso_in;  // sample on leading edge
        #63 sclk_out = cpol;  // trailing edge
        if (cpha)
          rx[b] = miso_in;
      end
      #63 select_n_out = 1'b1;
      mosi_out = ~mosi_out;  // released line shows no stale level
      #200;  // pause between bytes so the chain can be refilled
    end
  endtask
endmodule

// ===== spi_slave_port_bench.sv
`timescale 1ns/1ns
// register bus tasks plus framed serial traffic
module spi_slave_port_bench;
  logic        clock_in, rst_in, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, miso, oe, irq, ssn, sclk, mosi;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  rx, tx, mtx;
  logic        lsb;
  wire logic   miso_w;
  int          mismatches, compares;
  // undriven serial output shows the inverse, so stale levels are not trusted
  assign miso_w = oe ? miso : ~miso;

  spi_slave_port DUT (.clock_in(clock_in), .rst_in(rst_in), .awaddr_in(awaddr), .awvalid_in(awvalid),
    .awready_out(awready), .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready),
    .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
    .slave_select_n_in(ssn), .slave_serial_clock_in(sclk), .slave_serial_in_in(mosi),
    .slave_serial_out_out(miso), .slave_serial_out_oe_out(oe), .irq_out(irq));
  spi_master_model master (.miso_in(miso_w), .select_n_out(ssn), .sclk_out(sclk), .mosi_out(mosi));

  // 4 ns core clock
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    begin
      n = 0;
      // start right after a rising edge, whatever came before
      @(posedge clock_in);
      awaddr  <= {idx, 2'b00};
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
        @(posedge clock_in);
        if (awready)
          awvalid <= 1'b0;
        if (wready)
          wvalid <= 1'b0;
        n++;
      end while (!bvalid && n < 200);
      bready <= 1'b0;
      if (n >= 200)
        mismatches++;
      check({30'h0, bresp}, {30'h0, er});
      @(posedge clock_in);
    end
  endtask

  // bus read: rready held until rvalid
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] rs);
    int n;
    begin
      n = 0;
      // start right after a rising edge, whatever came before
      @(posedge clock_in);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
        @(posedge clock_in);
        if (arready)
          arvalid <= 1'b0;
        n++;
      end while (!rvalid && n < 200);
      d = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n >= 200)
        mismatches++;
      @(posedge clock_in);
    end
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, about 50k cycles
  initial
  begin
    #200000;
    mismatches++;
    complete_run();
  end

  // main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 10'h000;
    araddr = 10'h000;
    wdata  = 32'h0000_0000;
    wstrb  = 4'hf;
    rst_in = 1'b1;
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    rd(spi_slave_pkg::CFG_IDX, v, r);
    check(v, 32'h0000_0070);
    rd(spi_slave_pkg::STAT_IDX, v, r);
    check(v, 32'h0000_0000);
    rd(spi_slave_pkg::DATA_IDX, v, r);
    check(v, 32'h0000_0000);
    rd(8'h10, v, r);
    check({30'h0, r}, {30'h0, spi_slave_pkg::RESP_ERR});
    wr(8'h10, 32'h0000_0055, spi_slave_pkg::RESP_ERR);
    check({31'h0, oe}, 32'h0000_0000);
    // disabled core ignores a frame
    master.xfer(1'b0, 1'b0, 1'b0, 8'ha5, rx);
    rd(spi_slave_pkg::STAT_IDX, v, r);
    check(v, 32'h0000_0000);
    // every mode, both bit orders, interrupts unmasked
    for (int m = 0; m < 4; m++)
    begin
      lsb = m[1] ^ m[0];
      tx  = 8'h1d + 8'(m);
      mtx = 8'hc6 - 8'(m);
      wr(spi_slave_pkg::CFG_IDX, {28'h0, lsb, m[1], m[0], 1'b1}, spi_slave_pkg::RESP_OK);
      wr(spi_slave_pkg::DATA_IDX, {24'h0, tx}, spi_slave_pkg::RESP_OK);
      master.xfer(m[1], m[0], lsb, mtx, rx);
      check({24'h0, rx}, {24'h0, tx});
      check({31'h0, irq}, 32'h0000_0001);
      rd(spi_slave_pkg::DATA_IDX, v, r);
      check(v, {24'h0, mtx});
      rd(spi_slave_pkg::STAT_IDX, v, r);
      check(v, 32'h0000_0031);
      rd(spi_slave_pkg::STAT_IDX, v, r);
      check(v, 32'h0000_0000);
      check({31'h0, irq}, 32'h0000_0000);
    end
    // all sources masked, empty chain sends zero
    wr(spi_slave_pkg::CFG_IDX, 32'h0000_0071, spi_slave_pkg::RESP_OK);
    master.xfer(1'b0, 1'b0, 1'b0, 8'h3c, rx);
    check({24'h0, rx}, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    rd(spi_slave_pkg::STAT_IDX, v, r);
    check(v, 32'h0000_0031);
    // second write while deselected is dropped
    wr(spi_slave_pkg::DATA_IDX, 32'h0000_0081, spi_slave_pkg::RESP_OK);
    wr(spi_slave_pkg::DATA_IDX, 32'h0000_0042, spi_slave_pkg::RESP_OK);
    master.xfer(1'b0, 1'b0, 1'b0, 8'h00, rx);
    check({24'h0, rx}, 32'h0000_0081);
    master.xfer(1'b0, 1'b0, 1'b0, 8'h00, rx);
    check({24'h0, rx}, 32'h0000_0000);
    complete_run();
  end
endmodule
